//--- verilog/tsp_params.svh
// Constants for the serial temperature sensor port and its controller
`ifndef TSP_PARAMS_SVH
`define TSP_PARAMS_SVH

// Clock and timing
`define TSP_CLK_NS         5
`define TSP_CONV_MS        300
`define TSP_CONV_CYCLES    (`TSP_CONV_MS * 1000000 / `TSP_CLK_NS)
`define TSP_CS_LEAD_NS     100
`define TSP_CS_LEAD_CYC    ((`TSP_CS_LEAD_NS + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_SCK_MAX_KHZ    7000
`define TSP_SCK_HALF_CYC   ((1000000 + 2 * `TSP_SCK_MAX_KHZ * `TSP_CLK_NS - 1) / (2 * `TSP_SCK_MAX_KHZ * `TSP_CLK_NS))

// Serial word layout
`define TSP_WORD_BITS      16
`define TSP_DRIVE_BITS     14
`define TSP_TEMP_BITS      13
`define TSP_CFG_MIN_BITS   8
`define TSP_TEMP_RST       13'h1fe0
`define TSP_ID_CODE        8'h3c
`define TSP_SHDN_CODE      8'hff
`define TSP_ID_FETCH_CFG   16'h00ff
`define TSP_RESUME_CFG     16'h0000

// Controller register map
`define TSP_REG_CTRL       3'h0
`define TSP_REG_CFG        3'h1
`define TSP_REG_STATUS     3'h2
`define TSP_REG_TEMP       3'h3
`define TSP_REG_ID         3'h4
`define TSP_CTRL_OP_LSB    0
`define TSP_CTRL_LEN_LSB   8
`define TSP_STAT_BUSY      0
`define TSP_STAT_READY     1
`define TSP_READY_BIT      2

`endif

//--- verilog/tsp_pkg.sv
// Types shared by both ends of the sensor link
`default_nettype none
package tsp_pkg;

    typedef enum logic [2:0] {
        DS_IDLE  = 3'b001,
        DS_READ  = 3'b010,
        DS_WRITE = 3'b100
    } tsp_dev_state_t;

    typedef enum logic [3:0] {
        MS_IDLE  = 4'b0001,
        MS_LEAD  = 4'b0010,
        MS_SHIFT = 4'b0100,
        MS_TAIL  = 4'b1000
    } tsp_mst_state_t;

    typedef enum logic [1:0] {
        OP_NONE    = 2'h0,
        OP_READ    = 2'h1,
        OP_READ_WR = 2'h2,
        OP_ID      = 2'h3
    } tsp_op_t;

endpackage
`default_nettype wire

//--- verilog/tsp_if.sv
// Three-wire link between sensor and controller
`timescale 1ns/1ps
`default_nettype none
interface tsp_if;
    logic cs_n;
    logic sck;
    logic mst_sio_o;
    logic mst_sio_oe;
    logic dev_sio_o;
    logic dev_sio_oe;
    logic sio;

    // Undriven line reads high, as a pulled-up floating pin would
    assign sio = dev_sio_oe ? dev_sio_o : (mst_sio_oe ? mst_sio_o : 1'b1);

    modport dev (input cs_n, input sck, input sio, output dev_sio_o, output dev_sio_oe);
    modport mst (output cs_n, output sck, input sio, output mst_sio_o, output mst_sio_oe);
endinterface
`default_nettype wire

//--- verilog/tsp_sync.sv
// Two-flop synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module tsp_sync #(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // Asynchronous inputs
    input  wire logic [W-1:0]  d,
    // Synchronised level and edges
    output logic      [W-1:0]  lvl,
    output logic      [W-1:0]  rise,
    output logic      [W-1:0]  fall
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } tsp_sync_st_t;

    tsp_sync_st_t r;
    tsp_sync_st_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= {RST_VAL, RST_VAL, RST_VAL};
        end else begin
            r <= next_r;
        end
    end

    // Edges from the second and third flops only
    assign lvl  = r.s2;
    assign rise = r.s2 & ~r.s3;
    assign fall = ~r.s2 & r.s3;
endmodule
`default_nettype wire

//--- verilog/tsp_sensor.sv
// Sensor end: conversion pacing, mode register and serial port
`timescale 1ns/1ps
`default_nettype none
`include "tsp_params.svh"

// Contract
// - temperature is signed 13 bits, 1/16 C
// - lowest two word bits are never driven
// - bit two reads one after first conversion
// - continuous mode after power-up, result later
// - supply reset restarts continuous conversion
// - clock ignored while select is high
// - select fall opens, rise closes transaction
// - first bit at select fall, rest on falls
// - line released after fourteen bits
// - master may end a read early
// - conversion completes despite select going high
// - sixteen bits out, then sixteen config in
// - low config byte all ones means shutdown
// - master writes only the listed low codes
// - identification readable only in shutdown
// - id fetch: read, shut down, read, resume
// - master may read just leading sign bits
// - result in bits fifteen to three, MSB first
// - id code high byte, bits seven-two zero
module tsp_sensor
    import tsp_pkg::*;
#(
    parameter int unsigned CONV_CYCLES = `TSP_CONV_CYCLES,
    parameter logic [7:0]  ID_CODE     = `TSP_ID_CODE  // Arbitrary value
) (
    // Clock and power-on reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Link
    tsp_if.dev               link,
    // Sensing element
    input  wire logic [12:0] adc_code,
    // Status
    output logic             shutdown,
    output logic             first_done,
    output logic             conv_pulse
);
    typedef struct packed {
        tsp_dev_state_t st;
        logic [4:0]     bitn;
        logic [4:0]     wbits;
        logic [15:0]    word;
        logic [15:0]    cfg;
        logic           sio_o;
        logic           sio_oe;
        logic           shutdown;
        logic           first_done;
        logic           conv_pulse;
        logic [12:0]    temp;
        logic [31:0]    conv_cnt;
    } tsp_dev_st_t;

    tsp_dev_st_t r;
    tsp_dev_st_t next_r;

    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic       cs_sel;
    logic       cs_open;
    logic       cs_close;
    logic       sck_rise;
    logic       sck_fall;
    logic       sio_in;
    logic [15:0] temp_word;
    logic [15:0] id_word;
    logic [7:0]  low_byte;

    // Pins come from the controller's domain
    tsp_sync #(
        .W       (3),
        .RST_VAL (3'b001)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    ({link.sio, link.sck, link.cs_n}),
        .lvl  (pin_lvl),
        .rise (pin_rise),
        .fall (pin_fall)
    );

    assign cs_sel    = ~pin_lvl[0];
    assign cs_open   = pin_fall[0];
    assign cs_close  = pin_rise[0];
    assign sck_rise  = pin_rise[1];
    assign sck_fall  = pin_fall[1];
    assign sio_in    = pin_lvl[2];
    assign temp_word = {r.temp, r.first_done, 2'b00};
    assign id_word   = {ID_CODE, 8'h00};
    assign low_byte  = {r.cfg[6:0], sio_in};

    always_comb begin
        next_r            = r;
        next_r.conv_pulse = 1'b0;

        // Converter runs on its own outside shutdown, whatever the frames do
        if (r.shutdown) begin
            next_r.conv_cnt = '0;
        end else if (r.conv_cnt == CONV_CYCLES - 1) begin
            next_r.conv_cnt   = '0;
            next_r.temp       = adc_code;
            next_r.first_done = 1'b1;
            next_r.conv_pulse = 1'b1;
        end else begin
            next_r.conv_cnt = r.conv_cnt + 32'h1;
        end

        if (cs_open) begin
            next_r.st     = DS_READ;
            next_r.bitn   = '0;
            next_r.wbits  = '0;
            next_r.word   = temp_word;
            next_r.sio_o  = temp_word[15];
            next_r.sio_oe = 1'b1;
        end else if (cs_close || !cs_sel) begin
            // Short config write still counts once a full byte is in
            if (r.st == DS_WRITE && r.wbits >= 5'(`TSP_CFG_MIN_BITS)) begin
                next_r.shutdown = (r.cfg[7:0] == `TSP_SHDN_CODE);
            end
            next_r.st     = DS_IDLE;
            next_r.sio_oe = 1'b0;
        end else begin
            case (r.st)
                DS_READ: begin
                    if (sck_rise) begin
                        if (r.bitn == 5'(`TSP_WORD_BITS - 1)) begin
                            next_r.st    = DS_WRITE;
                            next_r.bitn  = '0;
                            next_r.wbits = '0;
                        end else begin
                            next_r.bitn = r.bitn + 5'h1;
                        end
                    end
                    if (sck_fall) begin
                        if (r.bitn < 5'(`TSP_DRIVE_BITS)) begin
                            next_r.sio_oe = 1'b1;
                            next_r.sio_o  = r.word[4'hf - r.bitn[3:0]];
                        end else begin
                            next_r.sio_oe = 1'b0;
                        end
                    end
                end
                DS_WRITE: begin
                    next_r.sio_oe = 1'b0;
                    if (sck_rise) begin
                        next_r.cfg   = {r.cfg[14:0], sio_in};
                        next_r.wbits = r.wbits + 5'h1;
                        if (r.wbits == 5'(`TSP_WORD_BITS - 1)) begin
                            next_r.shutdown = (low_byte == `TSP_SHDN_CODE);
                            next_r.st       = DS_READ;
                            next_r.bitn     = '0;
                            next_r.wbits    = '0;
                            // Id word replaces temperature only in shutdown
                            if (low_byte == `TSP_SHDN_CODE) begin
                                next_r.word = id_word;
                            end else begin
                                next_r.word = temp_word;
                            end
                        end
                    end
                end
                default: begin
                    next_r.st     = DS_IDLE;
                    next_r.sio_oe = 1'b0;
                end
            endcase
        end
    end

    // Reset stands for power-on and supply dips alike
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '{
                st:       DS_IDLE,
                bitn:     '0,
                wbits:    '0,
                word:     '0,
                cfg:      '0,
                sio_o:    1'b0,
                sio_oe:   1'b0,
                shutdown: 1'b0,
                first_done: 1'b0,
                conv_pulse: 1'b0,
                temp:     `TSP_TEMP_RST,
                conv_cnt: '0
            };
        end else begin
            r <= next_r;
        end
    end

    assign link.dev_sio_o  = r.sio_o;
    assign link.dev_sio_oe = r.sio_oe;
    assign shutdown        = r.shutdown;
    assign first_done      = r.first_done;
    assign conv_pulse      = r.conv_pulse;
endmodule
`default_nettype wire

//--- verilog/tsp_master.sv
// Controller end: register port and link sequencer
`timescale 1ns/1ps
`default_nettype none
`include "tsp_params.svh"
module tsp_master
    import tsp_pkg::*;
#(
    parameter int unsigned SCK_HALF = `TSP_SCK_HALF_CYC,
    parameter int unsigned CS_LEAD  = `TSP_CS_LEAD_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Link
    tsp_if.mst               link,
    // Register port
    input  wire logic [2:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             busy
);
    typedef struct packed {
        tsp_mst_state_t st;
        tsp_op_t        op;
        logic [4:0]     len;
        logic [1:0]     seg;
        logic [4:0]     bitn;
        logic [7:0]     div;
        logic           sck;
        logic           cs_n;
        logic           sio_o;
        logic           sio_oe;
        logic [15:0]    rx;
        logic [15:0]    temp;
        logic [15:0]    id;
        logic [15:0]    cfg;
        logic [15:0]    rdata;
        logic           busy;
    } tsp_mst_st_t;

    tsp_mst_st_t r;
    tsp_mst_st_t next_r;

    logic        sio_in;
    logic [4:0]  seg_len;
    logic [1:0]  last_seg;
    logic [15:0] wr_word;
    logic [15:0] cap;
    logic [4:0]  new_len;

    tsp_sync #(
        .W       (1),
        .RST_VAL (1'b1)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (link.sio),
        .lvl  (sio_in),
        .rise (),
        .fall ()
    );

    // Only the read of an OP_READ frame may be cut short
    assign seg_len  = (r.seg == 2'h0 && r.op == OP_READ) ? r.len : 5'(`TSP_WORD_BITS);
    assign last_seg = (r.op == OP_ID) ? 2'h3 : ((r.op == OP_READ_WR) ? 2'h1 : 2'h0);
    assign cap      = {r.rx[14:0], sio_in} << (5'(`TSP_WORD_BITS) - seg_len);
    assign new_len  = wdata[`TSP_CTRL_LEN_LSB +: 5];
    always_comb begin
        if (r.seg == 2'h1) begin
            wr_word = (r.op == OP_ID) ? `TSP_ID_FETCH_CFG : r.cfg;
        end else begin
            wr_word = `TSP_RESUME_CFG;
        end
    end

    always_comb begin
        next_r = r;

        if (rd) begin
            case (addr)
                `TSP_REG_CFG:    next_r.rdata = r.cfg;
                `TSP_REG_STATUS: next_r.rdata = {14'h0, r.temp[`TSP_READY_BIT], r.busy};
                `TSP_REG_TEMP:   next_r.rdata = r.temp;
                `TSP_REG_ID:     next_r.rdata = r.id;
                default:         next_r.rdata = '0;
            endcase
        end
        if (wr && addr == `TSP_REG_CFG) begin
            next_r.cfg = wdata;
        end

        case (r.st)
            MS_IDLE: begin
                // Start ignored while a frame runs
                if (wr && addr == `TSP_REG_CTRL
                    && wdata[`TSP_CTRL_OP_LSB +: 2] != OP_NONE) begin
                    next_r.op   = tsp_op_t'(wdata[`TSP_CTRL_OP_LSB +: 2]);
                    next_r.len  = (new_len == 5'h0 || new_len > 5'(`TSP_WORD_BITS))
                                  ? 5'(`TSP_WORD_BITS) : new_len;
                    next_r.cs_n = 1'b0;
                    next_r.st   = MS_LEAD;
                    next_r.div  = '0;
                    next_r.seg  = '0;
                    next_r.bitn = '0;
                    next_r.rx   = '0;
                    next_r.busy = 1'b1;
                end
            end
            MS_LEAD: begin
                next_r.div = r.div + 8'h1;
                if (r.div == 8'(CS_LEAD - 1)) begin
                    next_r.div = '0;
                    next_r.st  = MS_SHIFT;
                end
            end
            MS_SHIFT: begin
                next_r.div = r.div + 8'h1;
                if (r.div == 8'(SCK_HALF - 1)) begin
                    next_r.div = '0;
                    next_r.sck = ~r.sck;
                    if (!r.sck) begin
                        next_r.rx = {r.rx[14:0], sio_in};
                        if (r.bitn == seg_len - 5'h1) begin
                            if (r.seg == 2'h0) begin
                                next_r.temp = cap;
                            end
                            if (r.seg == 2'h2) begin
                                next_r.id = cap;
                            end
                            next_r.rx   = '0;
                            next_r.bitn = '0;
                            if (r.seg == last_seg) begin
                                next_r.st = MS_TAIL;
                            end else begin
                                next_r.seg = r.seg + 2'h1;
                            end
                        end else begin
                            next_r.bitn = r.bitn + 5'h1;
                        end
                    end else begin
                        // Write segments are the odd ones
                        next_r.sio_oe = r.seg[0];
                        next_r.sio_o  = wr_word[4'hf - r.bitn[3:0]];
                    end
                end
            end
            MS_TAIL: begin
                next_r.div = r.div + 8'h1;
                if (r.div == 8'(SCK_HALF - 1)) begin
                    next_r.sck    = 1'b0;
                    next_r.sio_oe = 1'b0;
                end
                if (r.div == 8'(SCK_HALF + CS_LEAD - 1)) begin
                    next_r.cs_n = 1'b1;
                    next_r.busy = 1'b0;
                    next_r.st   = MS_IDLE;
                end
            end
            default: begin
                next_r.st = MS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '{
                st: MS_IDLE, op: OP_NONE, len: 5'h10, seg: '0, bitn: '0,
                div: '0, sck: 1'b0, cs_n: 1'b1, sio_o: 1'b0, sio_oe: 1'b0,
                rx: '0, temp: '0, id: '0, cfg: '0, rdata: '0, busy: 1'b0
            };
        end else begin
            r <= next_r;
        end
    end

    assign link.cs_n       = r.cs_n;
    assign link.sck        = r.sck;
    assign link.mst_sio_o  = r.sio_o;
    assign link.mst_sio_oe = r.sio_oe;
    assign rdata           = r.rdata;
    assign busy            = r.busy;
endmodule
`default_nettype wire

//--- tb/tsp_link_sva.sv
// Protocol checks on the wires between controller and sensor
`timescale 1ns/1ps
`default_nettype none
module tsp_link_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Link wires
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mst_sio_o,
    input wire logic mst_sio_oe,
    input wire logic dev_sio_o,
    input wire logic dev_sio_oe
);
    logic       sck_q;
    logic [4:0] rise_cnt;

    // Rises seen while the sensor drives; cleared whenever it lets go
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sck_q    <= 1'b0;
            rise_cnt <= 5'h00;
        end else begin
            sck_q <= sck;
            if (!dev_sio_oe)
                rise_cnt <= 5'h00;
            else if (sck && !sck_q)
                rise_cnt <= rise_cnt + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_open;
        $fell(cs_n);
    endsequence
    sequence s_close;
        $rose(cs_n);
    endsequence

    property p_first_bit;   s_open |-> ##[1:4] dev_sio_oe; endproperty
    property p_lead;        s_open |-> !sck [*8]; endproperty
    property p_close;       s_close |-> ##[1:4] !dev_sio_oe; endproperty
    property p_idle_quiet;  cs_n [*5] |-> !dev_sio_oe; endproperty
    property p_sck_idle;    cs_n |-> !sck; endproperty
    property p_sck_high;    $rose(sck) |-> sck [*8]; endproperty
    property p_dev_hold;
        (sck && $past(sck) && dev_sio_oe && $past(dev_sio_oe)) |-> $stable(dev_sio_o);
    endproperty
    property p_mst_hold;
        (sck && $past(sck) && mst_sio_oe && $past(mst_sio_oe)) |-> $stable(mst_sio_o);
    endproperty
    property p_one_driver;  !(dev_sio_oe && mst_sio_oe); endproperty
    property p_mst_framed;  mst_sio_oe |-> !cs_n; endproperty
    property p_release;     dev_sio_oe |-> rise_cnt <= 5'd14; endproperty

    a_first_bit: assert property (p_first_bit)
        else $error("sensor silent after select fell");
    a_lead: assert property (p_lead)
        else $error("clock too soon after select fell");
    a_close: assert property (p_close)
        else $error("sensor still driving after select rose");
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("sensor drives while deselected");
    a_sck_idle: assert property (p_sck_idle)
        else $error("clock high while deselected");
    a_sck_high: assert property (p_sck_high)
        else $error("clock high phase too short");
    a_dev_hold: assert property (p_dev_hold)
        else $error("sensor bit changed while clock high");
    a_mst_hold: assert property (p_mst_hold)
        else $error("controller bit changed while clock high");
    a_one_driver: assert property (p_one_driver)
        else $error("both ends drive the data line");
    a_mst_framed: assert property (p_mst_framed)
        else $error("controller drives outside a frame");
    a_release: assert property (p_release)
        else $error("sensor drove past fourteen bits");
endmodule
`default_nettype wire

//--- tb/temp_sensor_serial_port_tb_top.sv
// Self-checking bench joining controller and sensor over the link
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_serial_port_tb_top;
    localparam int unsigned CONV = 1000;
    localparam logic [7:0]  ID   = 8'ha5;  // Arbitrary maker code

    logic        clk;
    logic        nrst;
    logic [12:0] adc_code;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        busy;
    logic        shutdown;
    logic        first_done;
    logic        conv_pulse;
    logic        saw_shdn;
    logic [15:0] d;
    int          n_fail;
    int          check_count;
    int          i;
    logic [15:0] tbl [7] = '{16'h3e87, 16'h0b87, 16'h000f, 16'h0007,
                             16'hffff, 16'hf387, 16'he487};
    logic [7:0]  codes [9] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h0f,
                               8'h1f, 8'h3f, 8'h7f, 8'hff};

    tsp_if link ();

    tsp_sensor #(.CONV_CYCLES(CONV), .ID_CODE(ID)) i_tsp_sensor (
        .clk(clk), .nrst(nrst), .link(link), .adc_code(adc_code),
        .shutdown(shutdown), .first_done(first_done), .conv_pulse(conv_pulse));

    tsp_master i_tsp_master (
        .clk(clk), .nrst(nrst), .link(link), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .busy(busy));

    tsp_link_sva i_tsp_link_sva (
        .clk(clk), .nrst(nrst), .cs_n(link.cs_n), .sck(link.sck),
        .mst_sio_o(link.mst_sio_o), .mst_sio_oe(link.mst_sio_oe),
        .dev_sio_o(link.dev_sio_o), .dev_sio_oe(link.dev_sio_oe));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    always @(posedge clk) if (shutdown === 1'b1) saw_shdn <= 1'b1;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d failures=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic reg_rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask

    // Start a frame and wait, bounded, for the controller to finish it
    task automatic run(input logic [15:0] ctrl);
        int k;
        reg_wr(3'h0, ctrl);
        for (k = 0; k < 4000; k++) begin
            @(posedge clk);
            #1;
            if (k > 2 && busy === 1'b0) break;
        end
        if (k == 4000) begin
            n_fail++;
            final_report();
        end
    endtask

    task automatic wait_conv();
        int k;
        for (k = 0; k < 2 * CONV; k++) begin
            @(posedge clk);
            #1;
            if (conv_pulse === 1'b1) break;
        end
        if (k == 2 * CONV) begin
            n_fail++;
            final_report();
        end
    endtask

    initial begin
        nrst        = 1'b0;
        adc_code    = tbl[0][15:3];
        addr        = 3'h0;
        wdata       = 16'h0000;
        wr          = 1'b0;
        rd          = 1'b0;
        saw_shdn    = 1'b0;
        n_fail      = 0;
        check_count = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        // Before any conversion: reset word, done flag low, low bits float
        run(16'h0001);
        reg_rd(3'h3, d);
        check(d, 16'hff03);
        reg_rd(3'h2, d);
        check(d & 16'h0002, 16'h0000);
        wait_conv();
        // Status mirrors the last word read, so fetch a fresh one first
        run(16'h0001);
        reg_rd(3'h2, d);
        check(d & 16'h0002, 16'h0002);
        for (i = 0; i < 7; i++) begin
            adc_code <= tbl[i][15:3];
            wait_conv();
            run(16'h0001);
            reg_rd(3'h3, d);
            check(d, tbl[i]);
        end
        // Early end of read: only the leading bits arrive
        for (i = 4; i <= 13; i += 9) begin
            run({3'h0, i[4:0], 8'h01});
            reg_rd(3'h3, d);
            check(d, tbl[6] & ~(16'hffff >> i));
        end
        reg_rd(3'h7, d);
        check(d, 16'h0000);
        // Upper byte is junk on purpose; only the low byte sets the mode
        for (i = 0; i < 9; i++) begin
            reg_wr(3'h1, {8'h5a, codes[i]});
            reg_rd(3'h1, d);
            check(d, {8'h5a, codes[i]});
            run(16'h0002);
            check({15'h0, shutdown}, {15'h0, codes[i] == 8'hff});
        end
        for (i = 0; i < 2 * CONV; i++) begin
            @(posedge clk);
            #1;
            if (conv_pulse === 1'b1) break;
        end
        check(i[15:0], 16'(2 * CONV));
        reg_wr(3'h1, 16'h0000);
        run(16'h0002);
        check({15'h0, shutdown}, 16'h0000);
        wait_conv();
        saw_shdn = 1'b0;
        run(16'h0003);
        reg_rd(3'h4, d);
        check(d, {ID, 8'h03});
        check({14'h0, saw_shdn, shutdown}, 16'h0002);
        // Supply dip in mid-frame, taken from shutdown
        reg_wr(3'h1, 16'h00ff);
        run(16'h0002);
        check({15'h0, shutdown}, 16'h0001);
        reg_wr(3'h0, 16'h0001);
        reg_rd(3'h2, d);
        check(d & 16'h0001, 16'h0001);
        repeat (100) @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        check({12'h0, link.cs_n, link.dev_sio_oe, first_done, shutdown}, 16'h0008);
        @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        run(16'h0001);
        reg_rd(3'h3, d);
        check(d, 16'hff03);
        wait_conv();
        final_report();
    end
endmodule
`default_nettype wire
